// ### hw/prmd_params.svh
// constants for the paged register map decoder: offsets, fields, resets
// assumes inclusion by the package and the design files only
`ifndef PRMD_PARAMS_SVH
`define PRMD_PARAMS_SVH

// word and result widths
`define PRMD_WORD_W        16
`define PRMD_RES_W         12

// command word fields
`define PRMD_CMD_RW_BIT    15
`define PRMD_CMD_PG_HI     14
`define PRMD_CMD_PG_LO     11
`define PRMD_CMD_AD_HI     10
`define PRMD_CMD_AD_LO     5

// page codes
`define PRMD_PAGE_RESULTS  4'h0
`define PRMD_PAGE_PEN_CTL  4'h1
`define PRMD_PAGE_AUDIO    4'h2
`define PRMD_PAGE_BUFFER   4'h3

// page 0 result offsets
`define PRMD_P0_HORIZ      7'h00
`define PRMD_P0_VERT       7'h01
`define PRMD_P0_PRESS1     7'h02
`define PRMD_P0_PRESS2     7'h03
`define PRMD_P0_SUPPLY     7'h05
`define PRMD_P0_FIRST_AUXILIARY_RESULT       7'h07
`define PRMD_P0_P0_SECOND_AUXILIARY_RESULT       7'h08
`define PRMD_P0_THERM1     7'h09
`define PRMD_P0_THERM2     7'h0A

// page 1 converter control: read-side status bits
`define PRMD_P1_CONV_CTL   7'h00
`define PRMD_P1_PEN_BIT    15
`define PRMD_P1_IDLE_BIT   14

// fixed words
`define PRMD_RESET_WORD    16'h0000
`define PRMD_PAST_END_WORD 16'hFFFF

`endif

// ### hw/prmd_pkg.sv
// types shared by the paged register map decoder
// assumes prmd_params.svh on the include path
package prmd_pkg;
  `include "prmd_params.svh"

  // link phase, one-hot
  typedef enum logic [3:0] {
    PRMD_IDLE = 4'b0001,
    PRMD_CMD  = 4'b0010,
    PRMD_RD   = 4'b0100,
    PRMD_WR   = 4'b1000
  } prmd_state_t;

  // conversion result update from the converter side
  typedef struct packed {
    logic                   valid;
    logic [5:0]             offset;
    logic [`PRMD_RES_W-1:0] value;
  } prmd_res_upd_t;

  // buffer location write from the converter side
  typedef struct packed {
    logic                    valid;
    logic [5:0]              addr;
    logic [`PRMD_WORD_W-1:0] data;
  } prmd_buf_wr_t;
endpackage

// ### hw/prmd_buf_mem.sv
// buffer window memory behind page 3, registered read data
// assumes one writer (converter side) and one reader (serial side)
module prmd_buf_mem #(
  parameter int DATA_W = 16,
  parameter int ADDR_W = 6
) (
  input  wire logic              sys_clk,
  input  wire logic              srst,
  input  wire logic              wr_en,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [DATA_W-1:0] wr_data,
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic      [DATA_W-1:0] rd_data
);
  localparam int DEPTH = 1 << ADDR_W;

  logic [DATA_W-1:0] mem_q [DEPTH];   // storage, no reset
  logic [DEPTH-1:0]  vld_q;           // location written since reset
  logic [DEPTH-1:0]  vld_d;
  logic [DATA_W-1:0] rd_d;

  ////////////////////////////////////////////////////////////////////////
  // next values: unwritten locations read as zero, never unknown
  always_comb
  begin
    vld_d = vld_q;
    if (wr_en)
    begin
      vld_d[wr_addr] = 1'b1;
    end
    rd_d = vld_q[rd_addr] ? mem_q[rd_addr] : '0;
  end

  // register stage
  always_ff @(posedge sys_clk)
  begin
    if (wr_en)
    begin
      mem_q[wr_addr] <= wr_data;
    end
    if (srst)
    begin
      vld_q   <= '0;
      rd_data <= '0;
    end
    else
    begin
      vld_q   <= vld_d;
      rd_data <= rd_d;
    end
  end
endmodule // prmd_buf_mem

// ### hw/prmd_reg_map.sv
// paged register map decoder behind a mode-1 serial slave port
// assumes serial pins synchronous to sys_clk, each sclk phase >= 4 cycles
//
// How it works
// R01: every register is one sixteen-bit word
// R02: four pages: results, two control, buffer
// R03: page 0 results at fixed offsets, rest reserved
// R04: reset clears every page 0 result
// R05: host writes to page 0 change nothing
// R06: results right-justified, top four bits zero
// R07: page 1 control registers at 00 through 0D
// R08: page 2 audio registers at 00 through 27
// R09: every page 3 offset maps a buffer location
// R10: read view and write store built separately
// R11: results held until replaced
// R12: command word: rw, page, offset, zeros
// R13: pointer advances; past page end reads ones
// R14: only pages 0 to 3 select registers
// R15: commands accepted only after select falls
// R16: reserved offsets read zero, ignore writes
`include "prmd_params.svh"
module prmd_reg_map
  import prmd_pkg::*;
#(
  parameter int P1_REGS = 14,
  parameter int P2_REGS = 40
) (
  input  wire logic                  sys_clk,
  input  wire logic                  srst,
  input  wire logic                  spi_sclk,
  input  wire logic                  spi_ss_n,
  input  wire logic                  spi_mosi,
  output logic                       spi_miso,
  output logic                       spi_miso_oe,
  input  wire prmd_res_upd_t         res_upd,
  input  wire prmd_buf_wr_t          buf_wr,
  input  wire logic                  pen_down,
  input  wire logic                  adc_idle,
  output logic [P1_REGS-1:0][15:0]   p1_ctl,
  output logic [P2_REGS-1:0][15:0]   p2_ctl
);

  ////////////////////////////////////////////////////////////////////////
  // decode helpers
  function automatic logic p0_valid(input logic [6:0] a);
    unique case (a)
      `PRMD_P0_HORIZ, `PRMD_P0_VERT, `PRMD_P0_PRESS1, `PRMD_P0_PRESS2,
      `PRMD_P0_SUPPLY, `PRMD_P0_FIRST_AUXILIARY_RESULT, `PRMD_P0_P0_SECOND_AUXILIARY_RESULT, `PRMD_P0_THERM1,
      `PRMD_P0_THERM2: p0_valid = 1'b1;
      default:         p0_valid = 1'b0;
    endcase
  endfunction

  // pointer stops one past the page so later words keep reading ones
  function automatic logic [6:0] next_ptr(input logic [6:0] p);
    next_ptr = p[6] ? p : 7'(p + 7'h01);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // link state
  prmd_state_t state_q, state_d;       // frame phase
  logic        sclk_q;                 // previous sclk sample
  logic        ss_q;                   // previous select sample
  logic [3:0]  cnt_q, cnt_d;           // bits of the current word
  logic [15:0] rx_q, rx_d;             // receive shifter
  logic [15:0] tx_q, tx_d;             // transmit shifter
  logic        miso_q, miso_d;         // driven data bit
  logic [3:0]  page_q, page_d;         // page from command
  logic [6:0]  ptr_q, ptr_d;           // offset pointer, bit 6 = past end
  logic [1:0]  pend_q, pend_d;         // read fetch pipeline
  logic        rise, fall, ss_fell;
  logic [15:0] word;                   // word completed this edge
  logic        wr_en;                  // write word complete
  logic [15:0] rd_word;                // read view of pointer
  logic [15:0] buf_rdata;

  // storage
  logic [10:0][11:0]        res_q, res_d;  // page 0 results
  logic [P1_REGS-1:0][15:0] p1_q, p1_d;    // page 1 stored writes
  logic [P2_REGS-1:0][15:0] p2_q, p2_d;    // page 2 stored writes

  assign rise    = spi_sclk & ~sclk_q;
  assign fall    = ~spi_sclk & sclk_q;
  assign ss_fell = ~spi_ss_n & ss_q;
  assign word    = {rx_q[14:0], spi_mosi};

  ////////////////////////////////////////////////////////////////////////
  // buffer window, page 3
  prmd_buf_mem #(
    .DATA_W (16),
    .ADDR_W (6)
  ) u_buf (
    .sys_clk (sys_clk),
    .srst    (srst),
    .wr_en   (buf_wr.valid),
    .wr_addr (buf_wr.addr),
    .wr_data (buf_wr.data),
    .rd_addr (ptr_q[5:0]),                         // R09
    .rd_data (buf_rdata)
  );

  ////////////////////////////////////////////////////////////////////////
  // read view: separate from the write store
  always_comb
  begin
    rd_word = `PRMD_RESET_WORD;                    // R16
    if (ptr_q[6])
    begin
      rd_word = `PRMD_PAST_END_WORD;               // R13
    end
    else
    begin
      unique case (page_q)                         // R02 R14
        `PRMD_PAGE_RESULTS:
          if (p0_valid(ptr_q))                     // R03
            rd_word = {4'h0, res_q[ptr_q[3:0]]};   // R06
        `PRMD_PAGE_PEN_CTL:
        begin
          if (ptr_q < 7'(P1_REGS))                 // R07
          begin
            rd_word = p1_q[ptr_q[3:0]];
            if (ptr_q == `PRMD_P1_CONV_CTL)
            begin
              rd_word[`PRMD_P1_PEN_BIT]  = pen_down; // R10
              rd_word[`PRMD_P1_IDLE_BIT] = adc_idle; // R10
            end
          end
        end
        `PRMD_PAGE_AUDIO:
          if (ptr_q < 7'(P2_REGS))                 // R08
            rd_word = p2_q[ptr_q[5:0]];
        `PRMD_PAGE_BUFFER: rd_word = buf_rdata;    // R09
        default:           rd_word = `PRMD_RESET_WORD; // R14
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // link next state
  always_comb
  begin
    state_d = state_q;
    cnt_d   = cnt_q;
    rx_d    = rx_q;
    tx_d    = tx_q;
    miso_d  = miso_q;
    page_d  = page_q;
    ptr_d   = ptr_q;
    pend_d  = {pend_q[0], 1'b0};
    wr_en   = 1'b0;
    if (spi_ss_n)
    begin
      // deselected: drop the frame
      state_d = PRMD_IDLE;
      cnt_d   = 4'h0;
      pend_d  = 2'h0;
      miso_d  = 1'b0;
    end
    else if (ss_fell)
    begin
      // fresh frame starts with a command word
      state_d = PRMD_CMD;                          // R15
      cnt_d   = 4'h0;
      miso_d  = 1'b0;
      tx_d    = '0;
    end
    else if (state_q != PRMD_IDLE)
    begin
      // first edge shifts out, second samples
      if (rise)
      begin
        miso_d = (state_q == PRMD_RD) ? tx_q[15] : 1'b0;
        tx_d   = {tx_q[14:0], 1'b0};
      end
      if (fall)
      begin
        rx_d  = word;
        cnt_d = 4'(cnt_q + 4'h1);
        if (cnt_q == 4'hF)                         // R01
        begin
          unique case (state_q)
            PRMD_CMD:
            begin
              page_d    = word[`PRMD_CMD_PG_HI:`PRMD_CMD_PG_LO]; // R12
              ptr_d     = {1'b0, word[`PRMD_CMD_AD_HI:`PRMD_CMD_AD_LO]};
              state_d   = word[`PRMD_CMD_RW_BIT] ? PRMD_RD : PRMD_WR;
              pend_d[0] = word[`PRMD_CMD_RW_BIT];
            end
            PRMD_RD:
            begin
              ptr_d     = next_ptr(ptr_q);         // R13
              pend_d[0] = 1'b1;
            end
            PRMD_WR:
            begin
              wr_en = ~ptr_q[6];
              ptr_d = next_ptr(ptr_q);             // R13
            end
            PRMD_IDLE: ;
          endcase
        end
      end
    end
    // fetch lands two cycles after the pointer settles (memory latency)
    if (pend_q[1] && !spi_ss_n)
      tx_d = rd_word;
  end

  // link registers
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      state_q <= PRMD_IDLE;
      sclk_q  <= 1'b0;
      ss_q    <= 1'b0;  // low: a select held low at reset is not a fall
      cnt_q   <= 4'h0;
      rx_q    <= '0;
      tx_q    <= '0;
      miso_q  <= 1'b0;
      page_q  <= 4'h0;
      ptr_q   <= 7'h00;
      pend_q  <= 2'h0;
    end
    else
    begin
      state_q <= state_d;
      sclk_q  <= spi_sclk;
      ss_q    <= spi_ss_n;
      cnt_q   <= cnt_d;
      rx_q    <= rx_d;
      tx_q    <= tx_d;
      miso_q  <= miso_d;
      page_q  <= page_d;
      ptr_q   <= ptr_d;
      pend_q  <= pend_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register store next values
  always_comb
  begin
    res_d = res_q;                                 // R11
    p1_d  = p1_q;
    p2_d  = p2_q;
    // converter updates; reserved result offsets dropped
    if (res_upd.valid && p0_valid({1'b0, res_upd.offset}))
      res_d[res_upd.offset[3:0]] = res_upd.value;
    // host writes: page 0 and page 3 ignore them
    if (wr_en)                                     // R05
    begin
      if (page_q == `PRMD_PAGE_PEN_CTL && ptr_q < 7'(P1_REGS)) // R16
        p1_d[ptr_q[3:0]] = rx_d;                   // R07 R10
      if (page_q == `PRMD_PAGE_AUDIO && ptr_q < 7'(P2_REGS))
        p2_d[ptr_q[5:0]] = rx_d;                   // R08
    end
  end

  // register store flops
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      res_q <= '0;                                 // R04
      p1_q  <= '0;
      p2_q  <= '0;
    end
    else
    begin
      res_q <= res_d;
      p1_q  <= p1_d;
      p2_q  <= p2_d;
    end
  end

  assign spi_miso    = miso_q;
  assign spi_miso_oe = ~spi_ss_n & (state_q != PRMD_IDLE);
  assign p1_ctl      = p1_q;
  assign p2_ctl      = p2_q;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  a_result_cleared: assert property ($past(srst) |-> res_q == '0) // R04
    else $error("results not cleared by reset");
  a_page0_readonly: assert property ( // R05
    wr_en && page_q == `PRMD_PAGE_RESULTS && !res_upd.valid
    |=> $stable(res_q)) else $error("page 0 changed by host write");
  a_result_held: assert property (!res_upd.valid |=> $stable(res_q)) // R11
    else $error("result changed without update");
  a_upper_zero: assert property ( // R06
    pend_q[1] && !spi_ss_n && page_q == `PRMD_PAGE_RESULTS && !ptr_q[6]
    |=> tx_q[15:12] == 4'h0) else $error("result not right-justified");
  a_p0_reserved: assert property ( // R03
    pend_q[1] && !spi_ss_n && page_q == `PRMD_PAGE_RESULTS
    && ptr_q == 7'h04 |=> tx_q == '0) else $error("page 0 gap not zero");
  a_past_end: assert property ( // R13
    pend_q[1] && !spi_ss_n && ptr_q[6] |=> tx_q == `PRMD_PAST_END_WORD)
    else $error("past page end not all ones");
  a_ptr_advance: assert property ( // R13
    !spi_ss_n && !ss_fell && fall && cnt_q == 4'hF && !ptr_q[6]
    && (state_q == PRMD_RD || state_q == PRMD_WR)
    |=> ptr_q == 7'($past(ptr_q) + 7'h01)) else $error("pointer stuck");
  a_rsvd_page: assert property ( // R14
    pend_q[1] && !spi_ss_n && page_q > `PRMD_PAGE_BUFFER && !ptr_q[6]
    |=> tx_q == '0) else $error("reserved page selected data");
  a_rsvd_write: assert property ( // R16
    wr_en && page_q == `PRMD_PAGE_PEN_CTL && ptr_q >= 7'(P1_REGS)
    |=> $stable(p1_q)) else $error("reserved offset written");
  a_cmd_after_fall: assert property ( // R15
    state_q == PRMD_IDLE && state_d == PRMD_CMD |-> ss_fell)
    else $error("command phase without select fall");
  a_word_length: assert property ( // R01
    state_q == PRMD_CMD && (state_d == PRMD_RD || state_d == PRMD_WR)
    |-> cnt_q == 4'hF && fall) else $error("command not sixteen bits");
  a_split_view: assert property ( // R10
    pend_q[1] && !spi_ss_n && page_q == `PRMD_PAGE_PEN_CTL
    && ptr_q == `PRMD_P1_CONV_CTL
    |=> tx_q[15] == $past(pen_down)) else $error("pen status not read");
  a_audio_store: assert property ( // R08
    wr_en && page_q == `PRMD_PAGE_AUDIO && ptr_q < 7'(P2_REGS)
    |=> p2_q[$past(ptr_q[5:0])] == $past(rx_d))
    else $error("audio write lost");
  a_buffer_read: assert property ( // R09
    pend_q[1] && !spi_ss_n && page_q == `PRMD_PAGE_BUFFER && !ptr_q[6]
    |=> tx_q == $past(buf_rdata)) else $error("buffer word not loaded");

  c_read_frame:  cover property (state_q == PRMD_RD && pend_q[1]);
  c_write_frame: cover property (wr_en && page_q == `PRMD_PAGE_PEN_CTL);
  c_past_end:    cover property (pend_q[1] && ptr_q[6]);
  c_buffer_read: cover property (pend_q[1] && page_q == `PRMD_PAGE_BUFFER);
endmodule // prmd_reg_map

// ### dv/prmd_host_model.sv
// host side model: mode-1 serial master driving the register link
// assumes sys_clk is the bench clock; tasks are called by the bench
module prmd_host_model (
  input  wire logic sys_clk,
  output logic      spi_sclk,
  output logic      spi_ss_n,
  output logic      spi_mosi,
  input  wire logic spi_miso
);
  timeunit 1ns;
  timeprecision 1ns;

  int   half = 4;     // cycles per sclk phase, 4 is the fastest allowed
  logic busy = 1'b0;  // high while the host owns the data line

  initial
  begin
    spi_sclk = 1'b0;
    spi_ss_n = 1'b0;
    spi_mosi = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////
  // released data line toggles so a stale bit is never mistaken
  always @(posedge sys_clk)
    if (!busy)
      spi_mosi <= ~spi_mosi;

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // select fall opens a frame
  task automatic open_frame();
    @(posedge sys_clk);
    spi_ss_n <= 1'b1;
    wait_cyc(half);
    spi_ss_n <= 1'b0;
    wait_cyc(half);
  endtask

  // select rise ends the frame and releases the data line
  task automatic close_frame();
    wait_cyc(half);
    spi_ss_n <= 1'b1;
    busy = 1'b0;
    wait_cyc(half);
  endtask

  // one word msb first: drive on rise, sample just before the fall
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    busy = 1'b1;
    @(posedge sys_clk);
    for (int i = 15; i >= 0; i--)
    begin
      spi_sclk <= 1'b1;
      spi_mosi <= tx[i];
      wait_cyc(half);
      rx[i] = spi_miso;
      spi_sclk <= 1'b0;
      wait_cyc(half);
    end
  endtask
endmodule // prmd_host_model

// ### dv/testbench.sv
// self-checking bench for the paged register map decoder
// assumes the host model drives the link; bench drives converter ports
module testbench;
  import prmd_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

`define CHK(g, e) \
  begin \
    n_compared++; \
    if ((g) !== (e)) \
    begin \
      num_errors++; \
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); \
    end \
  end

  logic              sys_clk = 1'b0;
  logic              srst    = 1'b1;
  logic              spi_sclk;
  logic              spi_ss_n;
  logic              spi_mosi;
  logic              spi_miso;
  logic              spi_miso_oe;
  prmd_res_upd_t     res_upd  = '0;
  prmd_buf_wr_t      buf_wr   = '0;
  logic              pen_down = 1'b0;
  logic              adc_idle = 1'b0;
  logic [13:0][15:0] p1_ctl;
  logic [39:0][15:0] p2_ctl;
  logic [15:0]       wd  [0:79];  // words sent after a command
  logic [15:0]       got [0:79];  // words returned
  logic [15:0]       rx;
  int                num_errors = 0;
  int                n_compared = 0;

  always #50 sys_clk = ~sys_clk;  // 10 MHz

  prmd_reg_map prmd_reg_map_inst (
    .sys_clk, .srst, .spi_sclk, .spi_ss_n, .spi_mosi, .spi_miso,
    .spi_miso_oe, .res_upd, .buf_wr, .pen_down, .adc_idle,
    .p1_ctl, .p2_ctl
  );

  prmd_host_model host_inst (
    .sys_clk, .spi_sclk, .spi_ss_n, .spi_mosi, .spi_miso
  );

  //////////////////////////////////////////////////////////////////////
  // one framed access: command then n data words
  task automatic xact(input logic rw, input logic [3:0] pg,
                      input logic [5:0] off, input int n);
    host_inst.open_frame();
    `CHK(spi_miso_oe, 1'b1)
    host_inst.xfer({rw, pg, off, 5'h00}, rx);
    for (int i = 0; i < n; i++)
      host_inst.xfer(wd[i], got[i]);
    host_inst.close_frame();
  endtask

  // one-cycle converter strobes
  task automatic upd(input logic [5:0] off, input logic [11:0] v);
    @(posedge sys_clk);
    res_upd <= '{1'b1, off, v};
    buf_wr  <= '{1'b1, off, {4'hB, v}};
    @(posedge sys_clk);
    res_upd <= '0;
    buf_wr  <= '0;
  endtask

  // page 0 view: reserved reads zero, past the page reads ones
  function automatic logic [15:0] p0_exp(input int a);
    if (a > 63)
      return 16'hFFFF;
    if (a == 4 || a == 6 || a > 10)
      return 16'h0000;
    return {4'h0, 12'(a * 273 + 291)};
  endfunction

  task automatic stop_test();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////
  // hang guard
  initial
  begin
    repeat (90000) @(posedge sys_clk);
    num_errors++;
    stop_test();
  end

  // main sequence
  initial
  begin
    repeat (5) @(posedge sys_clk);
    srst <= 1'b0;
    // select low since reset: no fall, so the write must be dropped
    host_inst.xfer(16'h0800, rx);
    host_inst.xfer(16'h1234, rx);
    `CHK(spi_miso_oe, 1'b0)
    host_inst.close_frame();
    `CHK(p1_ctl[0], 16'h0000)
    xact(1'b1, 4'h0, 6'h00, 11);
    for (int i = 0; i < 11; i++)
      `CHK(got[i], 16'h0000)
    // load results, plus buffer copies; reserved result offsets dropped
    for (int a = 0; a < 12; a++)
      upd(6'(a), 12'(a * 273 + 291));
    wd[0] = 16'hFFFF;
    xact(1'b0, 4'h0, 6'h00, 1);
    xact(1'b1, 4'h0, 6'h00, 66);
    for (int i = 0; i < 66; i++)
      `CHK(got[i], p0_exp(i))
    // page 1 burst, one word past the last register
    for (int i = 0; i < 15; i++)
      wd[i] = 16'h4000 + 16'(i * 273);
    xact(1'b0, 4'h1, 6'h00, 15);
    for (int i = 0; i < 14; i++)
      `CHK(p1_ctl[i], wd[i])
    // offset 0 reads status bits in 15:14 and the stored control bits in 13:0
    for (int k = 0; k < 2; k++)
    begin
      @(posedge sys_clk);
      pen_down <= k[0];
      adc_idle <= ~k[0];
      xact(1'b1, 4'h1, 6'h00, 15);
      `CHK(got[0], {k[0], ~k[0], wd[0][13:0]})
      for (int i = 1; i < 15; i++)
        `CHK(got[i], (i < 14) ? wd[i] : 16'h0000)
    end
    // page 2 end of map into reserved offsets
    for (int i = 0; i < 4; i++)
      wd[i] = 16'hC000 + 16'(i);
    xact(1'b0, 4'h2, 6'h26, 4);
    `CHK(p2_ctl[38], 16'hC000)
    `CHK(p2_ctl[39], 16'hC001)
    xact(1'b1, 4'h2, 6'h26, 4);
    for (int i = 0; i < 4; i++)
      `CHK(got[i], (i < 2) ? wd[i] : 16'h0000)
    // every reserved page code: writes land nowhere, reads zero
    wd[0] = 16'h0F0F;
    for (int p = 4; p < 16; p++)
    begin
      xact(1'b0, 4'(p), 6'h00, 1);
      xact(1'b1, 4'(p), 6'h00, 1);
      `CHK(got[0], 16'h0000)
    end
    `CHK(p1_ctl[0], wd[0] ^ 16'h0F0F ^ 16'h4000)
    // buffer window offset 0A and top offset 3F with a slow host
    upd(6'h3F, 12'h357);
    host_inst.half = 7;
    xact(1'b1, 4'h3, 6'h0A, 1);
    `CHK(got[0], {4'hB, 12'(10 * 273 + 291)})
    xact(1'b1, 4'h3, 6'h3F, 2);
    `CHK(got[0], 16'hB357)
    `CHK(got[1], 16'hFFFF)
    host_inst.half = 4;
    // second reset mid-run clears results and control words
    @(posedge sys_clk);
    srst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    xact(1'b1, 4'h0, 6'h00, 4);
    for (int i = 0; i < 4; i++)
      `CHK(got[i], 16'h0000)
    `CHK(p1_ctl[5], 16'h0000)
    stop_test();
  end
endmodule // testbench
